//--- hw/branch_jump_system_exec.sv
`timescale 1ns/1ps
// control-flow and system instruction execution stage
module branch_jump_system_exec
	import bj_pkg::*;
#(
	parameter int SREG_DEPTH = 16
) (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	// issue
	input  wire logic                  valid_i,
	input  insn_type                   insn_i,
	output logic                       ready_o,
	// system call table
	input  wire logic [XLEN-1:0]       table_ptr_i,
	input  wire logic [XLEN-1:0]       call_addr_i,
	input  wire logic [LVL_W-1:0]      call_lvl_i,
	input  wire logic [LVL_W-1:0]      call_run_lvl_i,
	output logic      [CALL_NUM_W-1:0] call_num_o,
	// sync drain status
	input  wire logic                  pipe_empty_i,
	input  wire logic                  mem_idle_i,
	// test and lock resource
	output logic                       lock_req_o,
	output logic      [XLEN-1:0]       lock_addr_o,
	input  wire logic                  lock_done_i,
	input  wire logic [XLEN-1:0]       lock_result_i,
	// results
	output logic                       redirect_o,
	output logic      [XLEN-1:0]       target_o,
	output wb_type                     wb_o,
	output logic                       user_file_o,
	output logic      [LVL_W-1:0]      level_o,
	output logic                       exc_o,
	output exc_type                    exc_code_o
);
	initial begin
		if (SREG_DEPTH < 2 || SREG_DEPTH > 256 || (SREG_DEPTH & (SREG_DEPTH - 1)) != 0) begin
			$error("SREG_DEPTH out of range");
		end
	end

	typedef enum logic [1:0] {S_IDLE, S_SYNC, S_LOCK, S_SREG} state_type;
	state_type state_r;
	insn_type  held_r;
	logic [LVL_W-1:0] level_r;
	logic [LVL_W-1:0] saved_lvl_r;
	logic user_file_r;

	function automatic logic [XLEN-1:0] sext(input logic [JMP_OFF_W-1:0] v, input int w);
		logic [XLEN-1:0] r;
		r = '0;
		for (int i = 0; i < XLEN; i++) r[i] = (i < w) ? v[i] : v[w-1];
		return r;
	endfunction

	logic fire;
	logic taken;
	logic [XLEN-1:0] link;
	assign fire = valid_i && ready_o;
	assign ready_o = (state_r == S_IDLE);
	assign link = (insn_i.pc & ~32'h00000003) + 32'(INSN_BYTES);
	assign call_num_o = insn_i.imm[CALL_NUM_W-1:0];

	always_comb begin
		unique case (insn_i.op)
			OP_BEQ:  taken = insn_i.src_a == insn_i.src_b;
			OP_BNE:  taken = insn_i.src_a != insn_i.src_b;
			OP_BGT:  taken = $signed(insn_i.src_a) > $signed(insn_i.src_b);
			OP_BLT:  taken = $signed(insn_i.src_a) < $signed(insn_i.src_b);
			default: taken = 1'b0;
		endcase
	end

	// special register access
	logic sreg_we;
	logic sreg_ok;
	logic [XLEN-1:0] sreg_rdata;
	logic [LVL_W-1:0] sreg_need;
	assign sreg_ok = level_r >= sreg_need;
	assign sreg_we = fire && insn_i.op == OP_SREG_WRITE && sreg_ok;
	sreg_table #(.DEPTH(SREG_DEPTH)) u_sreg (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.we_i    (sreg_we),
		.idx_i   (insn_i.imm[SR_IDX_W-1:0]),
		.wdata_i (insn_i.src_a),
		.wlvl_i  (sreg_need),
		.rdata_o (sreg_rdata),
		.need_o  (sreg_need)
	);

	// sequencing of multi-cycle operations
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_r <= S_IDLE;
			held_r  <= '0;
		end else begin
			unique case (state_r)
				S_IDLE: if (fire) begin
					held_r <= insn_i;
					if (insn_i.op == OP_SYNC) state_r <= S_SYNC;
					else if (insn_i.op == OP_TEST_LOCK) state_r <= S_LOCK;
					else if (insn_i.op == OP_SREG_READ && sreg_ok) state_r <= S_SREG;
				end
				S_SYNC: if (pipe_empty_i && mem_idle_i) state_r <= S_IDLE;
				S_LOCK: if (lock_done_i) state_r <= S_IDLE;
				S_SREG: state_r <= S_IDLE;
			endcase
		end
	end

	assign lock_req_o  = (state_r == S_LOCK);
	assign lock_addr_o = held_r.src_a;

	// permission level and active register file
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			level_r     <= LVL_RESET;
			saved_lvl_r <= LVL_RESET;
			user_file_r <= 1'b1;
		end else if (fire) begin
			if (insn_i.op == OP_SYSCALL && table_ptr_i != TABLE_NONE
					&& level_r >= call_lvl_i) begin
				saved_lvl_r <= level_r;
				level_r     <= call_run_lvl_i;
				user_file_r <= 1'b0;
			end else if (insn_i.op == OP_SYSRET) begin
				level_r     <= saved_lvl_r;
				user_file_r <= 1'b1;
			end else if (insn_i.op == OP_PRIV_RAISE) begin
				if (insn_i.lower ? insn_i.imm[LVL_W-1:0] <= level_r
						: insn_i.imm[LVL_W-1:0] >= level_r && level_r >= LVL_SUPER)
					level_r <= insn_i.imm[LVL_W-1:0];
			end
		end
	end
	assign level_o     = level_r;
	assign user_file_o = user_file_r;

	// redirect, writeback and exceptions
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			redirect_o <= 1'b0;
			target_o   <= '0;
			wb_o       <= '0;
			exc_o      <= 1'b0;
			exc_code_o <= EXC_NONE;
		end else begin
			redirect_o <= 1'b0;
			wb_o.en    <= 1'b0;
			exc_o      <= 1'b0;
			exc_code_o <= EXC_NONE;
			if (state_r == S_SREG) begin
				wb_o <= '{en: 1'b1, addr: held_r.rd, data: sreg_rdata};
			end else if (state_r == S_LOCK && lock_done_i) begin
				wb_o <= '{en: 1'b1, addr: held_r.rd, data: lock_result_i};
			end else if (fire) begin
				unique case (insn_i.op)
					OP_BEQ, OP_BNE, OP_BGT, OP_BLT: if (taken) begin
						redirect_o <= 1'b1;
						target_o <= insn_i.pc + sext(insn_i.imm, BR_OFF_W);
					end
					OP_REL_GOTO, OP_REL_CALL: begin
						redirect_o <= 1'b1;
						target_o <= insn_i.pc + sext(insn_i.imm, JMP_OFF_W);
						if (insn_i.op == OP_REL_CALL)
							wb_o <= '{en: 1'b1, addr: 5'h1F, data: link};
					end
					OP_REG_GOTO, OP_REG_CALL: begin
						redirect_o <= 1'b1;
						target_o <= insn_i.src_a + sext(insn_i.imm, JMP_OFF_W);
						if (insn_i.op == OP_REG_CALL)
							wb_o <= '{en: 1'b1, addr: 5'h1F, data: link};
					end
					OP_SYSCALL: begin
						if (table_ptr_i == TABLE_NONE) begin
							exc_o <= 1'b1;
							exc_code_o <= EXC_BAD_CALL;
						end else if (level_r < call_lvl_i) begin
							exc_o <= 1'b1;
							exc_code_o <= EXC_BAD_LEVEL;
						end else begin
							redirect_o <= 1'b1;
							target_o <= call_addr_i;
						end
					end
					OP_SREG_WRITE, OP_SREG_READ: if (!sreg_ok) begin
						exc_o <= 1'b1;
						exc_code_o <= EXC_BAD_LEVEL;
					end
					OP_PRIV_RAISE: if (insn_i.lower ? insn_i.imm[LVL_W-1:0] > level_r
							: !(insn_i.imm[LVL_W-1:0] >= level_r && level_r >= LVL_SUPER)) begin
						exc_o <= 1'b1;
						exc_code_o <= EXC_BAD_LEVEL;
					end
					default: ;
				endcase
			end
		end
	end

	property p_beq;
		@(posedge clk_i) disable iff (reset_i)
		fire && insn_i.op == OP_BEQ && insn_i.src_a == insn_i.src_b
			|=> redirect_o && target_o == $past(insn_i.pc) + sext($past(insn_i.imm), BR_OFF_W);
	endproperty
	a_beq: assert property (p_beq) else $error("beq target wrong");

	property p_bne_not;
		@(posedge clk_i) disable iff (reset_i)
		fire && insn_i.op == OP_BNE && insn_i.src_a == insn_i.src_b |=> !redirect_o;
	endproperty
	a_bne_not: assert property (p_bne_not) else $error("bne taken on equal");

	property p_blt;
		@(posedge clk_i) disable iff (reset_i)
		fire && insn_i.op == OP_BLT && $signed(insn_i.src_a) < $signed(insn_i.src_b)
			|=> redirect_o;
	endproperty
	a_blt: assert property (p_blt) else $error("blt not taken");

	property p_rel;
		@(posedge clk_i) disable iff (reset_i)
		fire && insn_i.op == OP_REL_GOTO
			|=> target_o == $past(insn_i.pc) + sext($past(insn_i.imm), JMP_OFF_W);
	endproperty
	a_rel: assert property (p_rel) else $error("relative jump target wrong");

	property p_reg;
		@(posedge clk_i) disable iff (reset_i)
		fire && insn_i.op == OP_REG_GOTO
			|=> target_o == $past(insn_i.src_a) + sext($past(insn_i.imm), JMP_OFF_W);
	endproperty
	a_reg: assert property (p_reg) else $error("register jump target wrong");

	property p_link;
		@(posedge clk_i) disable iff (reset_i)
		fire && insn_i.op == OP_REL_CALL
			|=> wb_o.en && wb_o.data == ($past(insn_i.pc) & ~32'h00000003) + 32'h00000004;
	endproperty
	a_link: assert property (p_link) else $error("link address wrong");

	property p_nocall;
		@(posedge clk_i) disable iff (reset_i)
		fire && insn_i.op == OP_SYSCALL && table_ptr_i == TABLE_NONE
			|=> exc_o && exc_code_o == EXC_BAD_CALL && !redirect_o;
	endproperty
	a_nocall: assert property (p_nocall) else $error("missing call exception");

	property p_sysret;
		@(posedge clk_i) disable iff (reset_i)
		fire && insn_i.op == OP_SYSRET |=> user_file_o;
	endproperty
	a_sysret: assert property (p_sysret) else $error("sysret kept system file");

	// a call issued right behind may write back; only an unasked write is wrong
	property p_sreg;
		@(posedge clk_i) disable iff (reset_i)
		fire && (insn_i.op == OP_SREG_READ || insn_i.op == OP_SREG_WRITE) && !sreg_ok
			|=> exc_o && exc_code_o == EXC_BAD_LEVEL ##1 !(wb_o.en && !$past(fire));
	endproperty
	a_sreg: assert property (p_sreg) else $error("special access not refused");

	property p_sync;
		@(posedge clk_i) disable iff (reset_i)
		state_r == S_SYNC && !(pipe_empty_i && mem_idle_i) |=> !ready_o;
	endproperty
	a_sync: assert property (p_sync) else $error("sync released early");
endmodule

//--- include/bj_pkg.sv
// package of constants and types for the control-flow and system execution block
package bj_pkg;
	localparam int XLEN         = 32;
	localparam int BR_OFF_W     = 14;
	localparam int JMP_OFF_W    = 21;
	localparam int LVL_W        = 3;
	localparam int SR_IDX_W     = 8;
	localparam int CALL_NUM_W   = 8;
	localparam int INSN_BYTES   = 4;
	localparam logic [LVL_W-1:0] LVL_RESET = 3'h0;
	localparam logic [LVL_W-1:0] LVL_SUPER = 3'h2;
	localparam logic [LVL_W-1:0] LVL_USER  = 3'h0;
	localparam logic [XLEN-1:0] TABLE_NONE = 32'h00000000;

	typedef enum logic [3:0] {
		OP_NONE, OP_BEQ, OP_BNE, OP_BGT, OP_BLT,
		OP_REL_GOTO, OP_REL_CALL, OP_REG_GOTO, OP_REG_CALL,
		OP_SYSCALL, OP_SYSRET, OP_SREG_WRITE, OP_SREG_READ,
		OP_SYNC, OP_TEST_LOCK, OP_PRIV_RAISE
	} op_type;

	typedef enum logic [1:0] {EXC_NONE, EXC_BAD_CALL, EXC_BAD_LEVEL} exc_type;

	// one decoded instruction from issue
	typedef struct packed {
		op_type            op;
		logic              lower;
		logic [XLEN-1:0]   pc;
		logic [XLEN-1:0]   src_a;
		logic [XLEN-1:0]   src_b;
		logic [JMP_OFF_W-1:0] imm;
		logic [4:0]        rd;
	} insn_type;

	// register file write request
	typedef struct packed {
		logic            en;
		logic [4:0]      addr;
		logic [XLEN-1:0] data;
	} wb_type;
endpackage

//--- hw/spr_table.sv
`timescale 1ns/1ps
// small special register store with per-entry minimum level
module sreg_table
	import bj_pkg::*;
#(
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	// access
	input  wire logic                 we_i,
	input  wire logic [SR_IDX_W-1:0]  idx_i,
	input  wire logic [XLEN-1:0]      wdata_i,
	input  wire logic [LVL_W-1:0]     wlvl_i,
	output logic      [XLEN-1:0]      rdata_o,
	output logic      [LVL_W-1:0]     need_o
);
	initial begin
		// the index is cut to the depth, so only a power of two keeps every cut index on an existing slot
		if (DEPTH < 2 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("special register table depth out of range");
		end
	end
	logic [XLEN-1:0]  mem_r [DEPTH];
	logic [LVL_W-1:0] lvl_r [DEPTH];
	logic [$clog2(DEPTH)-1:0] a;
	assign a = idx_i[$clog2(DEPTH)-1:0];
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_r[a] <= wdata_i;
		end
		rdata_o <= mem_r[a];
	end
	// level table takes wlvl_i on a write, which the stage wires to this entry's own level; reset makes everything supervisor-only
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < DEPTH; i++) lvl_r[i] <= LVL_SUPER;
		end else if (we_i) begin
			lvl_r[a] <= wlvl_i;
		end
	end
	assign need_o = lvl_r[a];
endmodule

//--- bench/bj_far_model.sv
`timescale 1ns/1ps
// far side model: syscall table lookup and a test-and-lock resource
module bj_far_model
	import bj_pkg::*;
#(
	parameter logic [XLEN-1:0] ERR_CODE = 32'h0000005A
) (
	// core side
	input  wire logic                  clk_i,
	input  wire logic [CALL_NUM_W-1:0] call_num_i,
	input  wire logic                  lock_req_i,
	input  wire logic [XLEN-1:0]       lock_addr_i,
	// bench control
	input  wire logic [3:0]            dly_i,
	// answers
	output logic      [XLEN-1:0]       call_addr_o,
	output logic      [LVL_W-1:0]      call_lvl_o,
	output logic      [LVL_W-1:0]      call_run_lvl_o,
	output logic                       lock_done_o,
	output logic      [XLEN-1:0]       lock_result_o
);
	logic [3:0] cnt_r = 4'h0;
	initial lock_done_o = 1'b0;
	initial lock_result_o = 32'h00000000;
	// odd call numbers demand level 1, so a user caller is refused
	assign call_addr_o    = {22'h0, call_num_i, 2'h0} + 32'h00008000;
	assign call_lvl_o     = {2'h0, call_num_i[0]};
	assign call_run_lvl_o = LVL_SUPER;
	// odd addresses are owned elsewhere; idle result line toggles so it never looks valid
	always @(posedge clk_i) begin
		lock_done_o <= 1'b0;
		lock_result_o <= ~lock_result_o;
		if (lock_req_i !== 1'b1 || lock_done_o) begin
			cnt_r <= 4'h0;
		end else if (cnt_r == dly_i) begin
			lock_done_o <= 1'b1;
			lock_result_o <= lock_addr_i[0] ? ERR_CODE : 32'h00000000;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule

//--- bench/branch_jump_system_exec_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the control-flow and system execution stage
module branch_jump_system_exec_tb_top
	import bj_pkg::*;
;
	localparam logic [31:0] PC  = 32'h00001000;
	localparam logic [31:0] ERR = 32'h0000005A;
	logic clk_i, reset_i, valid_i, ready_o, pipe_empty_i, mem_idle_i, lock_req, lock_done;
	logic redirect_o, user_file_o, exc_o;
	insn_type insn_i;
	wb_type wb_o;
	exc_type exc_code_o, ec;
	logic [31:0] table_ptr_i, call_addr, lock_addr, lock_result, target_o, t, wd, la;
	logic [2:0] call_lvl, call_run, level_o;
	logic [7:0] call_num;
	logic [4:0] wa;
	logic [3:0] dly;
	logic r, we, ex;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;

	branch_jump_system_exec uut (.clk_i(clk_i), .reset_i(reset_i), .valid_i(valid_i),
		.insn_i(insn_i), .ready_o(ready_o), .table_ptr_i(table_ptr_i),
		.call_addr_i(call_addr), .call_lvl_i(call_lvl), .call_run_lvl_i(call_run),
		.call_num_o(call_num), .pipe_empty_i(pipe_empty_i), .mem_idle_i(mem_idle_i),
		.lock_req_o(lock_req), .lock_addr_o(lock_addr), .lock_done_i(lock_done),
		.lock_result_i(lock_result), .redirect_o(redirect_o), .target_o(target_o),
		.wb_o(wb_o), .user_file_o(user_file_o), .level_o(level_o), .exc_o(exc_o),
		.exc_code_o(exc_code_o));
	bj_far_model #(.ERR_CODE(ERR)) far (.clk_i(clk_i), .call_num_i(call_num),
		.lock_req_i(lock_req), .lock_addr_i(lock_addr), .dly_i(dly),
		.call_addr_o(call_addr), .call_lvl_o(call_lvl), .call_run_lvl_o(call_run),
		.lock_done_o(lock_done), .lock_result_o(lock_result));

	function automatic insn_type mk(op_type op, logic lw, logic [31:0] a, logic [31:0] b,
		logic [20:0] im);
		mk = '{op: op, lower: lw, pc: PC, src_a: a, src_b: b, imm: im, rd: 5'h07};
	endfunction

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// gather every pulse of one instruction until the stage is idle again
	task automatic go(insn_type i);
		@(posedge clk_i);
		valid_i <= 1'b1;
		insn_i <= i;
		@(posedge clk_i);
		while (ready_o !== 1'b1) @(posedge clk_i);
		valid_i <= 1'b0;
		r = 0;
		we = 0;
		ec = EXC_NONE;
		// cleared so a missing pulse cannot pass on an earlier test's value
		t = '0;
		wa = '0;
		wd = '0;
		la = '0;
		for (int n = 0; n < 40; n++) begin
			@(negedge clk_i);
			if (redirect_o === 1'b1) begin
				r = 1;
				t = target_o;
			end
			if (wb_o.en === 1'b1) begin
				we = 1;
				wa = wb_o.addr;
				wd = wb_o.data;
			end
			if (exc_o === 1'b1) ec = exc_code_o;
			if (lock_req === 1'b1) la = lock_addr;
			if (ready_o === 1'b1 && n > 1) break;
		end
	endtask

	task automatic lnk(logic [31:0] d);
		chk("wb_en", 1, we);
		chk("wb_addr", 31, wa);
		chk("wb_data", d, wd);
	endtask

	task automatic t_branch();
		op_type ops [4] = '{OP_BEQ, OP_BNE, OP_BGT, OP_BLT};
		bit tk [8] = '{0, 1, 0, 1, 1, 0, 0, 0};
		// -1 against 1 catches an unsigned compare
		for (int k = 0; k < 8; k++) begin
			go(mk(ops[k%4], 0, k < 4 ? 32'hFFFFFFFF : 32'h5, k < 4 ? 32'h1 : 32'h5, 21'h003FF0));
			chk("br_taken", tk[k], r);
			if (tk[k]) chk("br_target", PC - 32'h10, t);
		end
		$display("branch test done");
	endtask

	task automatic t_jump();
		go(mk(OP_REL_GOTO, 0, 0, 0, 21'h1FFFF8));
		chk("j_target", PC - 32'h8, t);
		chk("j_nolink", 0, we);
		go(mk(OP_REL_CALL, 0, 0, 0, 21'h000040));
		chk("jal_target", PC + 32'h40, t);
		lnk(PC + 32'h4);
		go(mk(OP_REG_GOTO, 0, 32'h00002000, 0, 21'h000100));
		chk("reg_goto_target", 32'h00002100, t);
		go(mk(OP_REG_CALL, 0, 32'h00002000, 0, 21'h000100));
		chk("jrl_target", 32'h00002100, t);
		lnk(PC + 32'h4);
		$display("jump test done");
	endtask

	task automatic t_sys();
		go(mk(OP_SREG_WRITE, 0, 32'hCAFE0001, 0, 21'h5));
		chk("sreg_wr_user", EXC_BAD_LEVEL, ec);
		go(mk(OP_SREG_READ, 0, 0, 0, 21'h5));
		chk("sreg_rd_user", EXC_BAD_LEVEL, ec);
		chk("sreg_rd_user_wb", 0, we);
		go(mk(OP_PRIV_RAISE, 0, 0, 0, 21'h2));
		chk("raise_user", EXC_BAD_LEVEL, ec);
		go(mk(OP_SYSCALL, 0, 0, 0, 21'h4));
		chk("call_notable", EXC_BAD_CALL, ec);
		@(posedge clk_i);
		table_ptr_i <= 32'h00008000;
		go(mk(OP_SYSCALL, 0, 0, 0, 21'h3));
		chk("call_refused", EXC_BAD_LEVEL, ec);
		chk("call_refused_lvl", 0, level_o);
		go(mk(OP_SYSCALL, 0, 0, 0, 21'h4));
		chk("call_target", 32'h00008010, t);
		chk("call_lvl", LVL_SUPER, level_o);
		chk("call_file", 0, user_file_o);
		go(mk(OP_SREG_WRITE, 0, 32'hCAFE0001, 0, 21'h5));
		chk("sreg_wr_exc", EXC_NONE, ec);
		go(mk(OP_SREG_READ, 0, 0, 0, 21'h5));
		chk("sreg_rd_wb", 1, we);
		chk("sreg_rd_addr", 7, wa);
		chk("sreg_rd_data", 32'hCAFE0001, wd);
		go(mk(OP_PRIV_RAISE, 0, 0, 0, 21'h3));
		chk("raise_lvl", 3, level_o);
		go(mk(OP_PRIV_RAISE, 1, 0, 0, 21'h1));
		chk("lower_lvl", 1, level_o);
		go(mk(OP_PRIV_RAISE, 0, 0, 0, 21'h3));
		chk("raise_low", EXC_BAD_LEVEL, ec);
		go(mk(OP_PRIV_RAISE, 1, 0, 0, 21'h2));
		chk("lower_up", EXC_BAD_LEVEL, ec);
		chk("lower_up_lvl", 1, level_o);
		go(mk(OP_SYSRET, 0, 0, 0, 0));
		chk("ret_file", 1, user_file_o);
		chk("ret_lvl", 0, level_o);
		$display("system test done");
	endtask

	task automatic t_lock();
		for (int k = 0; k < 2; k++) begin
			dly = k ? 4'h6 : 4'h0;
			go(mk(OP_TEST_LOCK, 0, 32'h00000A40 + k, 0, 0));
			chk("lock_addr", 32'h00000A40 + k, la);
			chk("lock_wb", 1, we);
			chk("lock_rd", 7, wa);
			chk("lock_res", k ? ERR : 32'h0, wd);
		end
		$display("lock test done");
	endtask

	task automatic t_sync();
		@(posedge clk_i);
		pipe_empty_i <= 1'b0;
		mem_idle_i <= 1'b0;
		go(mk(OP_SYNC, 0, 0, 0, 0));
		chk("sync_hold", 0, ready_o);
		@(posedge clk_i);
		pipe_empty_i <= 1'b1;
		repeat (3) @(negedge clk_i);
		chk("sync_mem", 0, ready_o);
		@(posedge clk_i);
		mem_idle_i <= 1'b1;
		for (int n = 0; n < 4 && ready_o !== 1'b1; n++) @(negedge clk_i);
		chk("sync_done", 1, ready_o);
		$display("sync test done");
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			results();
		end
	end

	initial begin
		reset_i = 1'b1;
		valid_i = 1'b0;
		insn_i = '0;
		table_ptr_i = 32'h0;
		pipe_empty_i = 1'b1;
		mem_idle_i = 1'b1;
		dly = 4'h0;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		t_branch();
		t_jump();
		t_sys();
		t_lock();
		t_sync();
		results();
	end
endmodule
